// >>> glrc_cfg.svh
`ifndef GLRC_CFG_SVH
`define GLRC_CFG_SVH

// ----------------------------------------------------------------------------
// clock and frame reset rates
// ----------------------------------------------------------------------------
`define GLRC_CLK_HZ          64'd100000000
`define GLRC_FR_MHZ_2997     64'd2997
`define GLRC_FR_MHZ_3000     64'd3000
`define GLRC_FR_MHZ_6250     64'd6250
`define GLRC_FR_MHZ_14985    64'd14985
`define GLRC_FR_MHZ_15000    64'd15000

// ----------------------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define GLRC_ADDR_REF_CTRL   8'h00
`define GLRC_ADDR_STATUS     8'h04
`define GLRC_ADDR_OUT1       8'h08
`define GLRC_ADDR_OUT2       8'h0C
`define GLRC_ADDR_OUT3       8'h10
`define GLRC_ADDR_OFF_BASE   8'h20
`define GLRC_ADDR_OFF_LAST   8'h5F

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define GLRC_REF_STD_LSB     0
`define GLRC_REF_SEL_BIT     3
`define GLRC_REF_SRC_BIT     4
`define GLRC_REF_FRAME_LSB   5
`define GLRC_REF_LOSS_BIT    8
`define GLRC_ST_STATE_LSB    0
`define GLRC_ST_HD_LSB       2
`define GLRC_ST_CW_LSB       6
`define GLRC_ST_FALLBACK_BIT 9
`define GLRC_OUT_STD_LSB     0
`define GLRC_OUT_SIG_BIT     4
`define GLRC_CMD_OP_LSB      16

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define GLRC_RST_REF_STD     3'h0
`define GLRC_RST_FRAME       3'h0
`define GLRC_RST_OUT_STD     4'h0
`define GLRC_RST_OFFSET      16'h0000
`define GLRC_RST_STEP        16'h0001

`endif

// >>> glrc_pkg.sv
package glrc_pkg;

    typedef enum logic [2:0] {
        ntsc_burst_lock          = 3'h0,
        pal_burst_lock           = 3'h1,
        ntsc_burst_lock_field_id = 3'h2,
        ntsc_sync_lock           = 3'h3,
        pal_sync_lock            = 3'h4,
        hd_trilevel_lock         = 3'h5
    } glrc_ref_std_t;

    typedef enum logic [1:0] {
        GL_INTERNAL = 2'h0,
        GL_ABSENT   = 2'h1,
        GL_UNLOCKED = 2'h2,
        GL_LOCKED   = 2'h3
    } glrc_gl_state_t;

    // black output standards: 0 ntsc, 1 pal, 2 ntsc_without_setup, 3 hd (output two)
    // output three: 0 black_burst, 1..13 hd formats
    typedef enum logic [1:0] {
        OP_VALUE = 2'h0,
        OP_UP    = 2'h1,
        OP_DOWN  = 2'h2,
        OP_DEF   = 2'h3
    } glrc_op_t;

    typedef enum logic [2:0] {
        APB_IDLE = 3'b001,
        APB_RESP = 3'b010,
        APB_SPARE = 3'b100
    } glrc_apb_st_t;

    typedef struct packed {
        logic [2:0] lock_sync;
        logic [2:0] pres_sync;
        logic       lock_q;
        logic       pres_q;
        logic       lock_prev;
    } glrc_sync_t;

    typedef struct packed {
        glrc_apb_st_t    apb_st;
        logic            pready;
        logic            pslverr;
        logic [31:0]     prdata;
        glrc_ref_std_t   ref_std;
        logic            sel_cw;
        logic            src_ext;
        logic [2:0]      cw_frame;
        logic            loss_hold_state_on_loss;
        logic            fallback;
        glrc_sync_t      sy;
        glrc_gl_state_t  gl_state;
        logic [2:0][3:0] out_std;
        logic [1:0]      out_sig;
        logic [3:0][15:0] h_off;
        logic [3:0][15:0] h_step;
        logic [3:0][15:0] v_off;
        logic [3:0][15:0] v_step;
        logic [31:0]     fr_cnt;
        logic            frame_pulse;
        logic            use_ext;
        logic            keep_comp;
    } glrc_state_t;

endpackage : glrc_pkg

// >>> glrc_top.sv
// Operation
// (R1) reference standard holds six lock codes
// (R2) status reports internal, absent, unlocked, locked
// (R3) report incoming trilevel format, twelve codes
// (R4) input selector: reference or continuous-wave connector
// (R5) internal/external source setting, read back
// (R6) frame reset at chosen rate, zero keeps composite
// (R7) report measured continuous-wave frequency code
// (R8) on lock loss switch internal or hold_state_on_loss
// (R9) loss action reads back as two codes
// (R10) input horizontal offset: value, up, down, default
// (R11) input vertical offset: value, up, down, default
// (R12) each offset has step: value, min, max, default
// (R13) output one accepts ntsc, pal, no-setup only
// (R14) output two adds hd trilevel sync
// (R15) output three: black burst or hd formats
// (R16) signal type for outputs one, two, readable
// (R17) signal type choices depend on ntsc or pal
// (R18) output horizontal excess carries into vertical
// (R19) output vertical offset: value, up, down, default
// (R20) up/down change by stored step exactly
// (R21) reject illegal choice, keep stored value
// (R22) up/down saturate at limits
`include "glrc_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module glrc_top
    import glrc_pkg::*;
#(
    parameter logic [15:0] H_LINE   = 16'd64000,
    parameter logic [15:0] V_MAX    = 16'd1023,
    parameter logic [15:0] HSTEP_MAX = 16'd10000,
    parameter logic [15:0] VSTEP_MAX = 16'd100,
    parameter logic [31:0] FR_CNT_2997  = 32'((1000 * `GLRC_CLK_HZ) / `GLRC_FR_MHZ_2997),
    parameter logic [31:0] FR_CNT_3000  = 32'((1000 * `GLRC_CLK_HZ) / `GLRC_FR_MHZ_3000),
    parameter logic [31:0] FR_CNT_6250  = 32'((1000 * `GLRC_CLK_HZ) / `GLRC_FR_MHZ_6250),
    parameter logic [31:0] FR_CNT_14985 = 32'((1000 * `GLRC_CLK_HZ) / `GLRC_FR_MHZ_14985),
    parameter logic [31:0] FR_CNT_15000 = 32'((1000 * `GLRC_CLK_HZ) / `GLRC_FR_MHZ_15000)
) (
    input  wire logic              clk_i,
    input  wire logic              arst_n_i,
    input  wire logic              psel_i,
    input  wire logic              penable_i,
    input  wire logic              pwrite_i,
    input  wire logic [7:0]        paddr_i,
    input  wire logic [31:0]       pwdata_i,
    output logic                   pready_o,
    output logic [31:0]            prdata_o,
    output logic                   pslverr_o,
    input  wire logic              lock_i,
    input  wire logic              ref_present_i,
    input  wire logic [3:0]        hd_fmt_i,
    input  wire logic [2:0]        cw_freq_i,
    output logic [2:0]             ref_std_o,
    output logic                   sel_cw_o,
    output logic                   use_external_o,
    output logic                   keep_composite_o,
    output logic                   frame_reset_o,
    output logic [2:0][3:0]        out_std_o,
    output logic [1:0]             out_sig_o,
    output logic [3:0][15:0]       h_off_o,
    output logic [3:0][15:0]       v_off_o
);

    // ------------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------------
    function automatic logic [31:0] fr_period(input logic [2:0] code);
        case (code)
            3'h1:    fr_period = FR_CNT_2997;
            3'h2:    fr_period = FR_CNT_3000;
            3'h3:    fr_period = FR_CNT_6250;
            3'h4:    fr_period = FR_CNT_14985;
            3'h5:    fr_period = FR_CNT_15000;
            default: fr_period = 32'h0000_0001;
        endcase
    endfunction : fr_period

    function automatic logic std_ok(input logic [1:0] idx, input logic [3:0] code);
        case (idx)
            2'h0:    std_ok = (code <= 4'h2);  // [R13]
            2'h1:    std_ok = (code <= 4'h3);  // [R14]
            2'h2:    std_ok = (code <= 4'hD);  // [R15]
            default: std_ok = 1'b0;
        endcase
    endfunction : std_ok

    // field reference variants only exist on sd standards
    function automatic logic sig_ok(input logic [3:0] code, input logic sig);
        sig_ok = !sig || (code <= 4'h2);  // [R17]
    endfunction : sig_ok

    // up/down by the stored step, clipped to [0, hi]
    function automatic logic [15:0] step_sat(input logic [15:0] cur, input logic [15:0] stp,
                                             input logic up, input logic [15:0] hi);
        logic [16:0] sum;
        sum = 17'h0_0000;
        if (up) begin
            sum = {1'b0, cur} + {1'b0, stp};  // [R20]
            step_sat = (sum > {1'b0, hi}) ? hi : sum[15:0];  // [R22]
        end else begin
            step_sat = (cur < stp) ? 16'h0000 : cur - stp;  // [R22]
        end
    endfunction : step_sat

    function automatic logic [15:0] step_cmd(input glrc_op_t op, input logic [15:0] val,
                                             input logic [15:0] hi);
        case (op)
            OP_UP:   step_cmd = 16'h0001;  // [R12]
            OP_DOWN: step_cmd = hi;
            OP_DEF:  step_cmd = `GLRC_RST_STEP;
            default: step_cmd = val;
        endcase
    endfunction : step_cmd

    // ------------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------------
    glrc_state_t s_reg;
    glrc_state_t s_next;

    logic        acc;
    logic [1:0]  ch;
    logic [1:0]  sub;
    logic        is_off;
    logic        mapped;
    logic        wr_ok;
    logic [31:0] rd;
    glrc_op_t    op;
    logic [15:0] val;
    logic [15:0] carry;
    logic [15:0] h_rem;
    logic [16:0] v_sum;
    logic [1:0]  oidx;
    logic [3:0]  ostd;

    always_comb begin
        s_next = s_reg;
        acc    = psel_i && penable_i;
        is_off = (paddr_i >= `GLRC_ADDR_OFF_BASE) && (paddr_i <= `GLRC_ADDR_OFF_LAST)
                 && (paddr_i[1:0] == 2'h0);
        ch     = 2'(paddr_i[5:4] - 2'h2);
        sub    = paddr_i[3:2];
        op     = glrc_op_t'(pwdata_i[`GLRC_CMD_OP_LSB +: 2]);
        val    = pwdata_i[15:0];
        carry  = val / H_LINE;
        h_rem  = val % H_LINE;
        v_sum  = {1'b0, s_reg.v_off[ch]} + {1'b0, carry};
        oidx   = 2'(paddr_i[4:2] - 3'h2);
        ostd   = pwdata_i[`GLRC_OUT_STD_LSB +: 4];

        // --------------------------------------------------------------------
        // lock and presence come from the genlock core's pins
        // --------------------------------------------------------------------
        s_next.sy.lock_sync = {s_reg.sy.lock_sync[1:0], lock_i};
        s_next.sy.pres_sync = {s_reg.sy.pres_sync[1:0], ref_present_i};
        if (s_reg.sy.lock_sync[1] == s_reg.sy.lock_sync[2]) begin
            s_next.sy.lock_q = s_reg.sy.lock_sync[2];
        end
        if (s_reg.sy.pres_sync[1] == s_reg.sy.pres_sync[2]) begin
            s_next.sy.pres_q = s_reg.sy.pres_sync[2];
        end
        s_next.sy.lock_prev = s_reg.sy.lock_q;

        // --------------------------------------------------------------------
        // read mux and write legality
        // --------------------------------------------------------------------
        mapped = 1'b1;
        wr_ok  = 1'b1;
        rd     = 32'h0000_0000;
        if (is_off) begin
            case (sub)
                2'h0: rd[15:0] = s_reg.h_off[ch];
                2'h1: rd[15:0] = s_reg.h_step[ch];
                2'h2: rd[15:0] = s_reg.v_off[ch];
                default: rd[15:0] = s_reg.v_step[ch];
            endcase
            if (op == OP_VALUE) begin
                case (sub)
                    2'h0: wr_ok = (ch != 2'h0) || (val < H_LINE);  // [R21]
                    2'h1: wr_ok = (val != 16'h0000) && (val <= HSTEP_MAX);  // [R21]
                    2'h2: wr_ok = (val <= V_MAX);  // [R21]
                    default: wr_ok = (val != 16'h0000) && (val <= VSTEP_MAX);  // [R21]
                endcase
            end
        end else begin
            case (paddr_i)
                `GLRC_ADDR_REF_CTRL: begin
                    rd[`GLRC_REF_STD_LSB +: 3]   = s_reg.ref_std;  // [R1]
                    rd[`GLRC_REF_SEL_BIT]        = s_reg.sel_cw;  // [R4]
                    rd[`GLRC_REF_SRC_BIT]        = s_reg.src_ext;  // [R5]
                    rd[`GLRC_REF_FRAME_LSB +: 3] = s_reg.cw_frame;
                    rd[`GLRC_REF_LOSS_BIT]       = s_reg.loss_hold_state_on_loss;  // [R9]
                    wr_ok = (pwdata_i[`GLRC_REF_STD_LSB +: 3] <= 3'h5)
                            && (pwdata_i[`GLRC_REF_FRAME_LSB +: 3] <= 3'h5);  // [R21]
                end
                `GLRC_ADDR_STATUS: begin
                    rd[`GLRC_ST_STATE_LSB +: 2] = s_reg.gl_state;  // [R2]
                    rd[`GLRC_ST_HD_LSB +: 4]    = hd_fmt_i;  // [R3]
                    rd[`GLRC_ST_CW_LSB +: 3]    = cw_freq_i;  // [R7]
                    rd[`GLRC_ST_FALLBACK_BIT]   = s_reg.fallback;
                    wr_ok = 1'b0;
                end
                `GLRC_ADDR_OUT1, `GLRC_ADDR_OUT2, `GLRC_ADDR_OUT3: begin
                    rd[`GLRC_OUT_STD_LSB +: 4] = s_reg.out_std[oidx];
                    if (oidx != 2'h2) begin
                        rd[`GLRC_OUT_SIG_BIT] = s_reg.out_sig[oidx[0]];  // [R16]
                    end
                    wr_ok = std_ok(oidx, ostd)
                            && ((oidx == 2'h2) ? !pwdata_i[`GLRC_OUT_SIG_BIT]
                                               : sig_ok(ostd, pwdata_i[`GLRC_OUT_SIG_BIT]));  // [R21]
                end
                default: begin
                    mapped = 1'b0;
                    wr_ok  = 1'b0;
                end
            endcase
        end

        // --------------------------------------------------------------------
        // apb slave: one wait state, write lands on the completing edge
        // --------------------------------------------------------------------
        case (s_reg.apb_st)
            APB_IDLE: begin
                if (acc) begin
                    s_next.pready  = 1'b1;
                    s_next.prdata  = pwrite_i ? 32'h0000_0000 : rd;
                    s_next.pslverr = !mapped || (pwrite_i && !wr_ok);
                    s_next.apb_st  = APB_RESP;
                end
            end
            APB_RESP: begin
                s_next.pready  = 1'b0;
                s_next.pslverr = 1'b0;
                s_next.prdata  = 32'h0000_0000;
                s_next.apb_st  = APB_IDLE;
                // pslverr was decided from the same held request, so it gates the write
                if (acc && pwrite_i && !s_reg.pslverr) begin
                    if (is_off) begin
                        case (sub)
                            2'h0: begin
                                case (op)
                                    OP_UP:   s_next.h_off[ch] = step_sat(s_reg.h_off[ch], s_reg.h_step[ch],
                                                                         1'b1, 16'(H_LINE - 16'h0001));  // [R10] [R20]
                                    OP_DOWN: s_next.h_off[ch] = step_sat(s_reg.h_off[ch], s_reg.h_step[ch],
                                                                         1'b0, 16'h0000);  // [R10] [R20]
                                    OP_DEF:  s_next.h_off[ch] = `GLRC_RST_OFFSET;
                                    default: begin
                                        if (ch == 2'h0) begin
                                            s_next.h_off[ch] = val;  // [R10]
                                        end else begin
                                            s_next.h_off[ch] = h_rem;  // [R18]
                                            s_next.v_off[ch] = (v_sum > {1'b0, V_MAX}) ? V_MAX
                                                                                       : v_sum[15:0];  // [R18]
                                        end
                                    end
                                endcase
                            end
                            2'h1: s_next.h_step[ch] = step_cmd(op, val, HSTEP_MAX);  // [R12]
                            2'h2: begin
                                case (op)
                                    OP_UP:   s_next.v_off[ch] = step_sat(s_reg.v_off[ch], s_reg.v_step[ch],
                                                                         1'b1, V_MAX);  // [R11] [R19] [R20]
                                    OP_DOWN: s_next.v_off[ch] = step_sat(s_reg.v_off[ch], s_reg.v_step[ch],
                                                                         1'b0, 16'h0000);  // [R11] [R19]
                                    OP_DEF:  s_next.v_off[ch] = `GLRC_RST_OFFSET;
                                    default: s_next.v_off[ch] = val;  // [R11] [R19]
                                endcase
                            end
                            default: s_next.v_step[ch] = step_cmd(op, val, VSTEP_MAX);  // [R12]
                        endcase
                    end else begin
                        case (paddr_i)
                            `GLRC_ADDR_REF_CTRL: begin
                                s_next.ref_std   = glrc_ref_std_t'(pwdata_i[`GLRC_REF_STD_LSB +: 3]);  // [R1]
                                s_next.sel_cw    = pwdata_i[`GLRC_REF_SEL_BIT];  // [R4]
                                s_next.src_ext   = pwdata_i[`GLRC_REF_SRC_BIT];  // [R5]
                                s_next.cw_frame  = pwdata_i[`GLRC_REF_FRAME_LSB +: 3];  // [R6]
                                s_next.loss_hold_state_on_loss = pwdata_i[`GLRC_REF_LOSS_BIT];  // [R8]
                                s_next.fallback  = 1'b0;
                            end
                            `GLRC_ADDR_OUT1, `GLRC_ADDR_OUT2, `GLRC_ADDR_OUT3: begin
                                s_next.out_std[oidx] = ostd;  // [R13] [R14] [R15]
                                if (oidx != 2'h2) begin
                                    s_next.out_sig[oidx[0]] = pwdata_i[`GLRC_OUT_SIG_BIT];  // [R16] [R17]
                                end
                            end
                            default: begin
                            end
                        endcase
                    end
                end
            end
            default: begin
                s_next.apb_st = APB_IDLE;
                s_next.pready = 1'b0;
            end
        endcase

        // --------------------------------------------------------------------
        // loss of lock; placed after the register write so a loss in the
        // same cycle as a source rewrite still forces the fallback
        // --------------------------------------------------------------------
        if (s_reg.sy.lock_prev && !s_reg.sy.lock_q && s_reg.use_ext && !s_reg.loss_hold_state_on_loss) begin
            s_next.fallback = 1'b1;  // [R8]
        end
        s_next.use_ext = s_next.src_ext && !s_next.fallback;  // [R5] [R8]

        if (!s_reg.use_ext) begin
            s_next.gl_state = GL_INTERNAL;  // [R2]
        end else if (!s_reg.sy.pres_q) begin
            s_next.gl_state = GL_ABSENT;
        end else if (!s_reg.sy.lock_q) begin
            s_next.gl_state = GL_UNLOCKED;
        end else begin
            s_next.gl_state = GL_LOCKED;
        end

        // --------------------------------------------------------------------
        // continuous-wave frame reset
        // --------------------------------------------------------------------
        s_next.frame_pulse = 1'b0;
        s_next.keep_comp = (s_next.cw_frame == 3'h0);
        if (s_reg.sel_cw && (s_reg.cw_frame != 3'h0)) begin
            if (s_reg.fr_cnt >= fr_period(s_reg.cw_frame) - 32'h0000_0001) begin
                s_next.fr_cnt      = 32'h0000_0000;
                s_next.frame_pulse = 1'b1;  // [R6]
            end else begin
                s_next.fr_cnt = s_reg.fr_cnt + 32'h0000_0001;
            end
        end else begin
            s_next.fr_cnt = 32'h0000_0000;  // [R6]
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_reg           <= '0;
            s_reg.apb_st    <= APB_IDLE;
            s_reg.ref_std   <= glrc_ref_std_t'(`GLRC_RST_REF_STD);
            s_reg.cw_frame  <= `GLRC_RST_FRAME;
            s_reg.keep_comp <= 1'b1;
            s_reg.gl_state  <= GL_INTERNAL;
            s_reg.out_std   <= {3{`GLRC_RST_OUT_STD}};
            s_reg.h_off     <= {4{`GLRC_RST_OFFSET}};
            s_reg.v_off     <= {4{`GLRC_RST_OFFSET}};
            s_reg.h_step    <= {4{`GLRC_RST_STEP}};
            s_reg.v_step    <= {4{`GLRC_RST_STEP}};
        end else begin
            s_reg <= s_next;
        end
    end

    // ------------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------------
    assign pready_o         = s_reg.pready;
    assign prdata_o         = s_reg.prdata;
    assign pslverr_o        = s_reg.pslverr;
    assign ref_std_o        = s_reg.ref_std;
    assign sel_cw_o         = s_reg.sel_cw;
    assign use_external_o   = s_reg.use_ext;
    assign keep_composite_o = s_reg.keep_comp;
    assign frame_reset_o    = s_reg.frame_pulse;
    assign out_std_o        = s_reg.out_std;
    assign out_sig_o        = s_reg.out_sig;
    assign h_off_o          = s_reg.h_off;
    assign v_off_o          = s_reg.v_off;

endmodule : glrc_top

`default_nettype wire

// >>> glrc_pad.sv
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// >>> glrc_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module glrc_asserts
    import glrc_pkg::*;
#(parameter logic [15:0] H_LINE = 16'd64000, parameter logic [15:0] V_MAX = 16'd1023) (
    input wire logic clk_i, arst_n_i, psel_i, penable_i, pready_o, pslverr_o,
    input wire logic frame_reset_o, keep_composite_o,
    input wire logic [2:0] ref_std_o,
    input wire logic [2:0][3:0] out_std_o,
    input wire logic [3:0][15:0] h_off_o, v_off_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    ready_wait_a: assert property ($rose(penable_i) && psel_i |=> pready_o ##1 !pready_o) else $error("ready late");
    ref_std_a: assert property (ref_std_o <= 3'h5) else $error("ref std out of list");
    out_one_a: assert property (out_std_o[0] <= 4'h2) else $error("out1 std bad");
    out_two_a: assert property (out_std_o[1] <= 4'h3) else $error("out2 std bad");
    out_three_a: assert property (out_std_o[2] <= 4'hD) else $error("out3 std bad");
    refuse_keep_a: assert property (pready_o && pslverr_o |=> $stable(ref_std_o) && $stable(out_std_o))
        else $error("refused write changed state");
    h_sat_a: assert property (h_off_o[0] < H_LINE && h_off_o[1] < H_LINE) else $error("h offset past line");
    v_sat_a: assert property (v_off_o[1] <= V_MAX) else $error("v offset past max");
    pulse_one_a: assert property (frame_reset_o |=> !frame_reset_o) else $error("frame pulse long");
    keep_quiet_a: assert property ($past(keep_composite_o) && keep_composite_o |-> !frame_reset_o)
        else $error("pulse while keeping composite");
endmodule : glrc_asserts
bind glrc_top glrc_asserts #(.H_LINE(H_LINE), .V_MAX(V_MAX)) i_glrc_asserts (.*);
`default_nettype wire

// >>> glrc_core_model.sv
`timescale 1ns/100ps
`default_nettype none
module glrc_core_model (
    input  wire logic       clk_i,
    input  wire logic       lock_req_i,
    input  wire logic [6:0] code_i,
    output logic            lock_o,
    output logic            present_o,
    output logic [3:0]      hd_fmt_o,
    output logic [2:0]      cw_freq_o
);
    // detector codes hold_state_on_loss inside the legal lists; the loop itself is not modelled
    initial {lock_o, present_o, hd_fmt_o, cw_freq_o} = '0;
    always @(posedge clk_i) begin
        lock_o <= lock_req_i;
        present_o <= 1'b1;
        hd_fmt_o <= 4'(code_i[3:0] % 12);
        cw_freq_o <= 3'(code_i[6:4] % 5);
    end
endmodule : glrc_core_model
`default_nettype wire

// >>> glrc_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
module glrc_top_tb;
    import glrc_pkg::*;
    logic clk_i = 0, arst_n_i = 0, psel = 0, pen = 0, pwr = 0, lreq = 0, rdy, perr, err, keep, frp, selc, uext;
    logic [7:0] pa = 0;
    logic [31:0] pw = 0, prd, rd, seed = 32'h34FA503D;
    logic [2:0] rstd, cw;
    logic [2:0][3:0] ostd;
    logic [1:0] osig;
    logic [3:0][15:0] hoff, voff;
    logic lk, pr;
    logic [3:0] hd;
    logic [6:0] code = 0;
    logic [7:0] ta[8] = '{8'h08, 8'h0C, 8'h10, 8'h10, 8'h08, 8'h10, 8'h14, 8'h04};
    logic [31:0] td[8] = '{3, 3, 13, 14, 32'h11, 32'h10, 0, 0};
    logic te[8] = '{1, 0, 0, 1, 0, 1, 1, 1};
    int fails = 0, n_tests = 0, cnt, m = 1;
    always #5 clk_i = ~clk_i;
    glrc_core_model i_glrc_core_model (.clk_i(clk_i), .lock_req_i(lreq), .code_i(code), .lock_o(lk),
        .present_o(pr), .hd_fmt_o(hd), .cw_freq_o(cw));
    glrc_top #(.FR_CNT_2997(32'h14)) i_glrc_top (.clk_i(clk_i), .arst_n_i(arst_n_i), .psel_i(psel),
        .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pw), .pready_o(rdy), .prdata_o(prd),
        .pslverr_o(perr), .lock_i(lk), .ref_present_i(pr), .hd_fmt_i(hd), .cw_freq_i(cw), .ref_std_o(rstd),
        .sel_cw_o(selc), .use_external_o(uext), .keep_composite_o(keep), .frame_reset_o(frp),
        .out_std_o(ostd), .out_sig_o(osig), .h_off_o(hoff), .v_off_o(voff));
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk_i);
        {psel, pwr, pa, pw} <= {1'b1, w, a, d};
        @(posedge clk_i);
        pen <= 1;
        @(posedge clk_i);
        while (rdy !== 1'b1 && k < 50) begin
            k++;
            @(posedge clk_i);
        end
        fails += (k == 50);
        rd = prd;
        err = perr;
        {psel, pen} <= 2'b00;
        #1;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
        apb(1, a, d);
        chk(err, e);
    endtask : wr
    task automatic frames(input int exp);
        cnt = 0;
        repeat (30) @(posedge clk_i);
        repeat (100) begin
            @(posedge clk_i);
            cnt += frp;
        end
        chk(cnt, exp);
    endtask : frames
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : print_verdict
    initial begin
        #100us;
        fails++;
        print_verdict();
    end
    initial begin
        repeat (4) @(posedge clk_i);
        arst_n_i <= 1;
        #1 chk({keep, rstd, ostd}, {1'b1, 15'h0});
        for (int s = 0; s < 7; s++) begin
            wr(8'h00, s, s > 5);
            apb(0, 8'h00, 0);
            chk(rd[2:0], s > 5 ? 5 : s);
        end
        wr(8'h00, 32'h11A, 0);
        apb(0, 8'h00, 0);
        chk({rd[8:0], selc}, {9'h11A, 1'b1});
        $display("reference control done");
        wr(8'h00, 32'h28, 0);
        frames(5);
        wr(8'h00, 32'h08, 0);
        frames(0);
        $display("frame reset done");
        code = 7'(xs());
        lreq = 1;
        wr(8'h00, 32'h10, 0);
        repeat (10) @(posedge clk_i);
        apb(0, 8'h04, 0);
        chk(rd[9:0], {1'b0, 3'(code[6:4] % 5), 4'(code[3:0] % 12), 2'h3});
        lreq = 0;
        repeat (10) @(posedge clk_i);
        apb(0, 8'h04, 0);
        chk({uext, rd[9]}, 2'b01);
        wr(8'h00, 32'h110, 0);
        lreq = 1;
        repeat (10) @(posedge clk_i);
        lreq = 0;
        repeat (10) @(posedge clk_i);
        chk(uext, 1);
        $display("lock loss done");
        wr(8'h24, 30, 0);
        wr(8'h20, 100, 0);
        wr(8'h20, 32'h10000, 0);
        chk(hoff[0], 130);
        wr(8'h20, 32'h20000, 0);
        wr(8'h20, 32'h20000, 0);
        chk(hoff[0], 70);
        wr(8'h20, 10, 0);
        wr(8'h20, 32'h20000, 0);
        wr(8'h20, 64000, 1);
        chk(hoff[0], 0);
        wr(8'h30, 64005, 0);
        wr(8'h38, 32'h10000, 0);
        chk({hoff[1], voff[1]}, {16'd5, 16'd2});
        $display("offsets done");
        for (int i = 0; i < 8; i++) wr(ta[i], td[i], te[i]);
        chk({ostd, osig[0]}, {4'hD, 4'h3, 4'h1, 1'b1});
        for (int i = 0; i < 20; i++) begin
            td[0] = xs() & 32'hF;
            wr(8'h08, td[0], td[0] > 2);
            m = td[0] > 2 ? m : td[0];
            chk(ostd[0], m);
        end
        $display("outputs done");
        print_verdict();
    end
endmodule : glrc_top_tb
`default_nettype wire
